/* File: hw/lrec_top.sv */
// How it works
// - second regulator runs when its pin is high or control a bit 2 set
// - second regulator survives standby only with control a bit 0 set
// - with control a bit 1 set, second regulator starts only below 300mV
// - fixed regulator survives standby only with control a bit 3 set
// - with control a bit 4 set, fixed regulator starts only below 300mV
// - fixed regulator runs when its pin is high or control a bit 5 set
// - control a bits are all zero after power-on
// - termination variant enables fourth regulator from control b bit 2 only
// - termination variant sets fourth output from control b bits 4:3, 1.2V default
// - serial target answers at 0x78/0x79, termination variant 0x7A/0x7B
// - reset output pulled low while always-on regulator is 8% low
// - always-on regulator down to 2.0V; rest locked out below 2.5V
// - a disabled 300mA regulator has its output discharged to ground
// - registers return to power-on values when serial supply drops below 1V
//
// Purpose: serial register bank and enable control of the linear regulators
// Assumes: analog comparators deliver the threshold inputs as levels
// Notes: sdaOe high pulls the data line low; resetOutOe high pulls reset low
`include "lrec_params.svh"
module lrec_top #(
    parameter bit TERM_VARIANT = 1'b0
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic clkEn,
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    input wire logic secondRegEnablePin,
    input wire logic fixedRegEnablePin,
    input wire logic fourthRegEnablePin,
    input wire logic standbyReq,
    input wire logic secondBelow300mv,
    input wire logic fixedBelow300mv,
    input wire logic fourthBelow300mv,
    input wire logic alwaysOnLow,
    input wire logic vinAbove2v0,
    input wire logic vinAbove2v5,
    input wire logic serialSupplyLow,
    output logic alwaysOnEnable,
    output logic secondRegOn,
    output logic secondRegDischarge,
    output logic fixedRegOn,
    output logic fixedRegDischarge,
    output logic fourthRegOn,
    output logic fourthRegDischarge,
    output lrec_pkg::lrec_level_type fourthRegLevel,
    output logic resetOutOe
);
    import lrec_pkg::*;

    localparam logic [7:0] DEV_ADDR = TERM_VARIANT ? `LREC_ADDR_TERM_WR : `LREC_ADDR_WR;
    // bus lines sit in positions 1:0 and idle high, so reset brings no false edge
    localparam logic [`LREC_IN_COUNT-1:0] SYNC_IDLE = {{(`LREC_IN_COUNT-2){1'b0}}, 2'h3};

    logic [`LREC_IN_COUNT-1:0] rawIn;
    logic [`LREC_IN_COUNT-1:0] syncA_ff;
    logic [`LREC_IN_COUNT-1:0] syncB_ff;
    logic sclPrev_ff;
    logic sdaPrev_ff;
    logic sclS, sdaS, supplyLow, regReset;
    logic sclRise, sclFall, startSeen, stopSeen;
    lrec_state_type state_ff;
    lrec_byte_type kind_ff;
    logic [2:0] bitCnt_ff;
    logic [7:0] shift_ff;
    logic [7:0] subAddr_ff;
    logic isRead_ff;
    logic ackDriven_ff;
    logic sdaOe_ff;
    logic [7:0] byteIn;
    logic [7:0] rdByte;
    logic wrPulse;
    logic [7:0] ctlA_ff;
    logic [7:0] ctlB_ff;
    lrec_level_type level_ff;
    logic resetOut_ff;
    logic alwaysOn_ff;
    logic [2:0] pinReq, softReq, keepReq, drainReq, belowIn, railOn, railDis;

    function automatic lrec_level_type decodeLevel(input logic [1:0] sel);
        case (sel)
            2'h0: decodeLevel = LREC_1V2;
            2'h1: decodeLevel = LREC_2V5;
            2'h2: decodeLevel = LREC_2V8;
            default: decodeLevel = LREC_3V0;
        endcase
    endfunction

    // two-stage synchronisers for every pin and comparator
    assign rawIn = {serialSupplyLow, vinAbove2v5, vinAbove2v0, alwaysOnLow, fourthBelow300mv,
                    fixedBelow300mv, secondBelow300mv, standbyReq, fourthRegEnablePin,
                    fixedRegEnablePin, secondRegEnablePin, sdaIn, sclIn};

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            syncA_ff <= SYNC_IDLE;
            syncB_ff <= SYNC_IDLE;
            sclPrev_ff <= 1'b1;
            sdaPrev_ff <= 1'b1;
        end
        else if (clkEn)
        begin
            syncA_ff <= rawIn;
            syncB_ff <= syncA_ff;
            sclPrev_ff <= syncB_ff[`LREC_IN_SCL];
            sdaPrev_ff <= syncB_ff[`LREC_IN_SDA];
        end
    end

    assign sclS = syncB_ff[`LREC_IN_SCL];
    assign sdaS = syncB_ff[`LREC_IN_SDA];
    assign supplyLow = syncB_ff[`LREC_IN_SUPLOW];
    assign regReset = sys_rst | (supplyLow & clkEn);
    assign sclRise = sclS & ~sclPrev_ff;
    assign sclFall = ~sclS & sclPrev_ff;
    assign startSeen = sclS & sclPrev_ff & sdaPrev_ff & ~sdaS;
    assign stopSeen = sclS & sclPrev_ff & ~sdaPrev_ff & sdaS;
    assign byteIn = {shift_ff[6:0], sdaS};
    assign wrPulse = clkEn & sclRise & ~startSeen & ~stopSeen
                     & (state_ff == ST_WDATA) & (bitCnt_ff == 3'h7);

    always_comb
    begin
        case (subAddr_ff)
            `LREC_OFS_CTLA: rdByte = ctlA_ff;
            `LREC_OFS_CTLB: rdByte = ctlB_ff;
            `LREC_OFS_STAT:
            begin
                rdByte = 8'h00;
                rdByte[`LREC_S_ON2] = railOn[0];
                rdByte[`LREC_S_ON3] = railOn[1];
                rdByte[`LREC_S_ON4] = railOn[2];
                rdByte[`LREC_S_RESET_OUTPUT] = resetOut_ff;
                rdByte[`LREC_S_UVOK] = syncB_ff[`LREC_IN_VIN25];
            end
            default: rdByte = 8'h00;
        endcase
    end

    // two-wire target protocol
    always_ff @(posedge clk_sys)
    begin
        if (regReset)
        begin
            state_ff <= ST_IDLE;
            kind_ff <= BK_ADDR;
            bitCnt_ff <= 3'h0;
            shift_ff <= 8'h00;
            subAddr_ff <= 8'h00;
            isRead_ff <= 1'b0;
            ackDriven_ff <= 1'b0;
            sdaOe_ff <= 1'b0;
        end
        else if (clkEn)
        begin
            if (startSeen)
            begin
                state_ff <= ST_ADDR;
                bitCnt_ff <= 3'h0;
                sdaOe_ff <= 1'b0;
            end
            else if (stopSeen)
            begin
                state_ff <= ST_IDLE;
                sdaOe_ff <= 1'b0;
            end
            else if (sclRise)
            begin
                case (state_ff)
                    ST_ADDR, ST_SUB, ST_WDATA:
                    begin
                        shift_ff <= byteIn;
                        bitCnt_ff <= bitCnt_ff + 3'h1;
                        ackDriven_ff <= 1'b0;
                        if (bitCnt_ff == 3'h7)
                        begin
                            if (state_ff == ST_ADDR)
                            begin
                                kind_ff <= BK_ADDR;
                                isRead_ff <= byteIn[0];
                                // only the own address is acknowledged
                                state_ff <= (byteIn[7:1] == DEV_ADDR[7:1]) ? ST_ACKOUT : ST_IDLE;
                            end
                            else if (state_ff == ST_SUB)
                            begin
                                kind_ff <= BK_SUB;
                                subAddr_ff <= byteIn;
                                state_ff <= ST_ACKOUT;
                            end
                            else
                            begin
                                kind_ff <= BK_DATA;
                                subAddr_ff <= subAddr_ff + 8'h01;
                                state_ff <= ST_ACKOUT;
                            end
                        end
                    end
                    ST_RDATA:
                    begin
                        bitCnt_ff <= bitCnt_ff + 3'h1;
                        if (bitCnt_ff == 3'h7)
                        begin
                            state_ff <= ST_ACKIN;
                        end
                    end
                    ST_ACKIN:
                    begin
                        bitCnt_ff <= 3'h0;
                        if (sdaS)
                        begin
                            state_ff <= ST_IDLE;
                        end
                        else
                        begin
                            subAddr_ff <= subAddr_ff + 8'h01;
                            state_ff <= ST_RDATA;
                        end
                    end
                    default:
                    begin
                    end
                endcase
            end
            else if (sclFall)
            begin
                case (state_ff)
                    ST_ACKOUT:
                    begin
                        if (!ackDriven_ff)
                        begin
                            sdaOe_ff <= 1'b1;
                            ackDriven_ff <= 1'b1;
                        end
                        else
                        begin
                            bitCnt_ff <= 3'h0;
                            if (kind_ff == BK_ADDR && isRead_ff)
                            begin
                                state_ff <= ST_RDATA;
                                sdaOe_ff <= ~rdByte[7];
                            end
                            else
                            begin
                                sdaOe_ff <= 1'b0;
                                state_ff <= (kind_ff == BK_ADDR) ? ST_SUB : ST_WDATA;
                            end
                        end
                    end
                    ST_RDATA: sdaOe_ff <= ~rdByte[3'h7 - bitCnt_ff];
                    ST_ACKIN: sdaOe_ff <= 1'b0;
                    default:
                    begin
                    end
                endcase
            end
        end
    end

    // control registers
    always_ff @(posedge clk_sys)
    begin
        if (regReset)
        begin
            ctlA_ff <= `LREC_CTL_RESET;
            ctlB_ff <= `LREC_CTL_RESET;
        end
        else if (wrPulse)
        begin
            if (subAddr_ff == `LREC_OFS_CTLA)
            begin
                ctlA_ff <= byteIn & `LREC_CTLA_MASK;
            end
            if (subAddr_ff == `LREC_OFS_CTLB)
            begin
                ctlB_ff <= byteIn & `LREC_CTLB_MASK;
            end
        end
    end

    // fourth regulator level, reset monitor and always-on enable
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            level_ff <= LREC_1V2;
            resetOut_ff <= 1'b1;
            alwaysOn_ff <= 1'b0;
        end
        else if (clkEn)
        begin
            level_ff <= decodeLevel(ctlB_ff[`LREC_B_SEL_HI:`LREC_B_SEL_LO]);
            resetOut_ff <= syncB_ff[`LREC_IN_AOLOW];
            alwaysOn_ff <= syncB_ff[`LREC_IN_VIN20];
        end
    end

    assign pinReq = {TERM_VARIANT ? 1'b0 : syncB_ff[`LREC_IN_EN4],
                     syncB_ff[`LREC_IN_EN3], syncB_ff[`LREC_IN_EN2]};
    assign softReq = {ctlB_ff[`LREC_B_EN4], ctlA_ff[`LREC_A_EN3], ctlA_ff[`LREC_A_EN2]};
    assign keepReq = {ctlB_ff[`LREC_B_KEEP4], ctlA_ff[`LREC_A_KEEP3], ctlA_ff[`LREC_A_KEEP2]};
    assign drainReq = {ctlB_ff[`LREC_B_DIS4], ctlA_ff[`LREC_A_DIS3], ctlA_ff[`LREC_A_DIS2]};
    assign belowIn = {syncB_ff[`LREC_IN_LOW4], syncB_ff[`LREC_IN_LOW3], syncB_ff[`LREC_IN_LOW2]};

    // pin or bit enables, standby keep-alive, drained start, lockout
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : gRail
            lrec_rail uRail (
                .clk_sys(clk_sys),
                .sys_rst(sys_rst),
                .clkEn(clkEn),
                .reqPin(pinReq[gi]),
                .reqSoft(softReq[gi]),
                .keepAlive(keepReq[gi]),
                .dischargedOnly(drainReq[gi]),
                .belowLimit(belowIn[gi]),
                .standby(syncB_ff[`LREC_IN_STBY]),
                .supplyOk(syncB_ff[`LREC_IN_VIN25]),
                .railOn(railOn[gi]),
                .railDischarge(railDis[gi])
            );
        end
    endgenerate

    assign sdaOut = 1'b0;
    assign sdaOe = sdaOe_ff;
    assign alwaysOnEnable = alwaysOn_ff;
    assign secondRegOn = railOn[0];
    assign fixedRegOn = railOn[1];
    assign fourthRegOn = railOn[2];
    assign secondRegDischarge = railDis[0];
    assign fixedRegDischarge = railDis[1];
    assign fourthRegDischarge = railDis[2];
    assign fourthRegLevel = level_ff;
    assign resetOutOe = resetOut_ff;

    chk_second_source: assert property (@(posedge clk_sys) disable iff (sys_rst)
        $rose(railOn[0]) |-> $past(syncB_ff[`LREC_IN_EN2] | ctlA_ff[`LREC_A_EN2]))
        else $error("second regulator started without pin or bit");
    chk_second_standby: assert property (@(posedge clk_sys) disable iff (sys_rst)
        clkEn && syncB_ff[`LREC_IN_STBY] && !ctlA_ff[`LREC_A_KEEP2] |=> !railOn[0])
        else $error("second regulator kept in standby");
    chk_second_drained: assert property (@(posedge clk_sys) disable iff (sys_rst)
        $rose(railOn[0]) |-> $past(!ctlA_ff[`LREC_A_DIS2] | syncB_ff[`LREC_IN_LOW2]))
        else $error("second regulator started on charged output");
    chk_fixed_standby: assert property (@(posedge clk_sys) disable iff (sys_rst)
        clkEn && syncB_ff[`LREC_IN_STBY] && !ctlA_ff[`LREC_A_KEEP3] |=> !railOn[1])
        else $error("fixed regulator kept in standby");
    chk_fixed_drained: assert property (@(posedge clk_sys) disable iff (sys_rst)
        $rose(railOn[1]) |-> $past(!ctlA_ff[`LREC_A_DIS3] | syncB_ff[`LREC_IN_LOW3]))
        else $error("fixed regulator started on charged output");
    chk_fixed_source: assert property (@(posedge clk_sys) disable iff (sys_rst)
        $rose(railOn[1]) |-> $past(syncB_ff[`LREC_IN_EN3] | ctlA_ff[`LREC_A_EN3]))
        else $error("fixed regulator started without pin or bit");
    chk_ctla_reset: assert property (@(posedge clk_sys)
        sys_rst |=> ctlA_ff == `LREC_CTL_RESET)
        else $error("control a not cleared by reset");
    chk_term_source: assert property (@(posedge clk_sys) disable iff (sys_rst)
        TERM_VARIANT && $rose(railOn[2]) |-> $past(ctlB_ff[`LREC_B_EN4]))
        else $error("fourth regulator started without its bit");
    chk_level_code: assert property (@(posedge clk_sys) disable iff (sys_rst)
        clkEn && ctlB_ff[`LREC_B_SEL_HI:`LREC_B_SEL_LO] == 2'h2 |=> level_ff == LREC_2V8)
        else $error("level select decoded wrongly");
    chk_addr_ack: assert property (@(posedge clk_sys) disable iff (sys_rst)
        $rose(sdaOe_ff) && state_ff == ST_ACKOUT && kind_ff == BK_ADDR
        |-> shift_ff[7:1] == DEV_ADDR[7:1])
        else $error("foreign address acknowledged");
    chk_reset_out: assert property (@(posedge clk_sys) disable iff (sys_rst)
        clkEn && syncB_ff[`LREC_IN_AOLOW] |=> resetOutOe)
        else $error("reset output not asserted");
    chk_uvlo_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
        clkEn && !syncB_ff[`LREC_IN_VIN25] |=> railOn == 3'h0)
        else $error("regulator on under lockout");
    chk_off_drain: assert property (@(posedge clk_sys) disable iff (sys_rst)
        railDis == ~railOn)
        else $error("discharge does not follow enable");
    chk_supply_clear: assert property (@(posedge clk_sys) disable iff (sys_rst)
        clkEn && supplyLow |=> ctlA_ff == 8'h00 && ctlB_ff == 8'h00)
        else $error("registers kept through serial supply loss");

    cov_reg_write: cover property (@(posedge clk_sys) disable iff (sys_rst) wrPulse);
    cov_reg_read: cover property (@(posedge clk_sys) disable iff (sys_rst)
        state_ff == ST_ACKIN ##1 state_ff == ST_RDATA);
    cov_second_on: cover property (@(posedge clk_sys) disable iff (sys_rst) $rose(railOn[0]));
endmodule

/* File: common/lrec_params.svh */
// Purpose: constants of the linear regulator enable control block
// Assumes: 8-bit serial registers, one sub-address byte per transfer
// Notes: register sub-addresses and status layout are local choices
`ifndef LREC_PARAMS_SVH
`define LREC_PARAMS_SVH

// two-wire target addresses, write form
`define LREC_ADDR_WR 8'h78
`define LREC_ADDR_TERM_WR 8'h7a

// register sub-addresses
`define LREC_OFS_CTLA 8'h00
`define LREC_OFS_CTLB 8'h01
`define LREC_OFS_STAT 8'h02

// reset value and writable masks
`define LREC_CTL_RESET 8'h00
`define LREC_CTLA_MASK 8'h3f
`define LREC_CTLB_MASK 8'h1f

// control register a fields
`define LREC_A_KEEP2 0
`define LREC_A_DIS2 1
`define LREC_A_EN2 2
`define LREC_A_KEEP3 3
`define LREC_A_DIS3 4
`define LREC_A_EN3 5

// control register b fields
`define LREC_B_KEEP4 0
`define LREC_B_DIS4 1
`define LREC_B_EN4 2
`define LREC_B_SEL_LO 3
`define LREC_B_SEL_HI 4

// status register fields
`define LREC_S_ON2 0
`define LREC_S_ON3 1
`define LREC_S_ON4 2
`define LREC_S_RESET_OUTPUT 3
`define LREC_S_UVOK 4

// synchronised input vector positions
`define LREC_IN_SCL 0
`define LREC_IN_SDA 1
`define LREC_IN_EN2 2
`define LREC_IN_EN3 3
`define LREC_IN_EN4 4
`define LREC_IN_STBY 5
`define LREC_IN_LOW2 6
`define LREC_IN_LOW3 7
`define LREC_IN_LOW4 8
`define LREC_IN_AOLOW 9
`define LREC_IN_VIN20 10
`define LREC_IN_VIN25 11
`define LREC_IN_SUPLOW 12
`define LREC_IN_COUNT 13

`endif

/* File: common/lrec_pkg.sv */
// Purpose: types of the linear regulator enable control block
// Assumes: nothing
// Notes: level order follows the two-bit select code
package lrec_pkg;
    typedef enum {LREC_1V2, LREC_2V5, LREC_2V8, LREC_3V0} lrec_level_type;
    typedef enum {ST_IDLE, ST_ADDR, ST_SUB, ST_WDATA, ST_ACKOUT, ST_RDATA, ST_ACKIN} lrec_state_type;
    typedef enum {BK_ADDR, BK_SUB, BK_DATA} lrec_byte_type;
endpackage

/* File: hw/lrec_rail.sv */
// Purpose: enable, standby and start gating of one 300 mA regulator
// Assumes: all inputs already on the clk_sys domain
// Notes: discharge switch is on whenever the rail is off
module lrec_rail (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic clkEn,
    input wire logic reqPin,
    input wire logic reqSoft,
    input wire logic keepAlive,
    input wire logic dischargedOnly,
    input wire logic belowLimit,
    input wire logic standby,
    input wire logic supplyOk,
    output logic railOn,
    output logic railDischarge
);
    logic wantOn;
    logic nxt_railOn;
    logic railOn_ff;
    logic railDischarge_ff;

    // pin or soft bit, dropped in standby unless kept alive
    assign wantOn = (reqPin | reqSoft) & supplyOk & (~standby | keepAlive);

    always_comb
    begin
        nxt_railOn = 1'b0;
        if (wantOn)
        begin
            // a rail already up stays up; a start may wait for a drained output
            nxt_railOn = railOn_ff | ~dischargedOnly | belowLimit;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            railOn_ff <= 1'b0;
            railDischarge_ff <= 1'b1;
        end
        else if (clkEn)
        begin
            railOn_ff <= nxt_railOn;
            railDischarge_ff <= ~nxt_railOn;
        end
    end

    assign railOn = railOn_ff;
    assign railDischarge = railDischarge_ff;
endmodule

/* File: verif/lrec_host_model.sv */
// Purpose: two-wire bus controller standing in for the host processor
// Assumes: data line resolved by the bench with a pull-up to high
// Notes: clock high phase lasts eight clk_sys cycles, low phase between bits sixteen
module lrec_host_model (
    input wire logic clk_sys,
    input wire logic sdaLine,
    output logic sclPin,
    output logic sdaRel
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        sclPin = 1'b1;
        sdaRel = 1'b1;
    end
    task automatic half();
        repeat (8) @(posedge clk_sys);
    endtask
    // start or repeated start, data falls while clock high
    task automatic startCond();
        @(posedge clk_sys);
        sdaRel <= 1'b1;
        half();
        sclPin <= 1'b1;
        half();
        sdaRel <= 1'b0;
        half();
        sclPin <= 1'b0;
        half();
    endtask
    task automatic stopCond();
        sdaRel <= 1'b0;
        half();
        sclPin <= 1'b1;
        half();
        sdaRel <= 1'b1;
        half();
    endtask
    // data moves only while clock low, sampled late in the high phase
    task automatic bitXfer(input logic b, output logic r);
        sdaRel <= b;
        half();
        sclPin <= 1'b1;
        half();
        r = sdaLine;
        sclPin <= 1'b0;
        half();
    endtask
    // msb first, low in ninth bit means accepted
    task automatic sendByte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bitXfer(d[i], r);
        bitXfer(1'b1, r);
        ack = ~r;
    endtask
    task automatic recvByte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
            bitXfer(1'b1, d[i]);
        bitXfer(last, r);
    endtask
endmodule

/* File: verif/test_linear_regulator_enable_control.sv */
// Purpose: self-checking bench of the linear regulator enable control
// Assumes: base and termination parts share one two-wire bus
// Notes: rail cases run from a table, special cases follow
`include "lrec_params.svh"
module test_linear_regulator_enable_control;
    import lrec_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    // io bits: en2 en3 stby low2 low3 exp2 exp3
    typedef struct packed {
        logic [7:0] ctl;
        logic [6:0] io;
    } lrec_row_type;
    localparam lrec_row_type ROWS [8] = '{'{8'h00, 7'h42}, '{8'h04, 7'h02},
        '{8'h20, 7'h01}, '{8'h00, 7'h21}, '{8'h00, 7'h70}, '{8'h09, 7'h73},
        '{8'h12, 7'h60}, '{8'h12, 7'h6f}};
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic en2 = 1'b0, en3 = 1'b0, en4 = 1'b0, stby = 1'b0, low2 = 1'b0, low3 = 1'b0;
    logic vin20 = 1'b1, vin25 = 1'b1, aoLow = 1'b0, supLow = 1'b0;
    logic sdaOe, sdaOeT, on2, on3, on4, on4T, dis2, rstOe, aoEn;
    lrec_level_type lvl, lvlT;
    lrec_level_type lv [4] = '{LREC_1V2, LREC_2V5, LREC_2V8, LREC_3V0};
    wire sclPin, sdaRel;
    wire sdaLine = sdaRel & ~sdaOe & ~sdaOeT;
    int n_errors = 0, check_count = 0, cycles = 0;

    lrec_host_model host (.clk_sys(clk_sys), .sdaLine(sdaLine), .sclPin(sclPin),
        .sdaRel(sdaRel));
    lrec_top dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .clkEn(1'b1), .sclIn(sclPin),
        .sdaIn(sdaLine), .sdaOut(), .sdaOe(sdaOe), .secondRegEnablePin(en2),
        .fixedRegEnablePin(en3), .fourthRegEnablePin(en4), .standbyReq(stby),
        .secondBelow300mv(low2), .fixedBelow300mv(low3), .fourthBelow300mv(1'b0),
        .alwaysOnLow(aoLow), .vinAbove2v0(vin20), .vinAbove2v5(vin25),
        .serialSupplyLow(supLow), .alwaysOnEnable(aoEn), .secondRegOn(on2),
        .secondRegDischarge(dis2), .fixedRegOn(on3), .fixedRegDischarge(),
        .fourthRegOn(on4), .fourthRegDischarge(), .fourthRegLevel(lvl),
        .resetOutOe(rstOe));
    lrec_top #(.TERM_VARIANT(1'b1)) dutTerm (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .clkEn(1'b1), .sclIn(sclPin), .sdaIn(sdaLine), .sdaOut(), .sdaOe(sdaOeT),
        .secondRegEnablePin(en2), .fixedRegEnablePin(en3), .fourthRegEnablePin(en4),
        .standbyReq(stby), .secondBelow300mv(low2), .fixedBelow300mv(low3),
        .fourthBelow300mv(1'b0), .alwaysOnLow(aoLow), .vinAbove2v0(vin20),
        .vinAbove2v5(vin25), .serialSupplyLow(supLow), .alwaysOnEnable(),
        .secondRegOn(), .secondRegDischarge(), .fixedRegOn(), .fixedRegDischarge(),
        .fourthRegOn(on4T), .fourthRegDischarge(), .fourthRegLevel(lvlT),
        .resetOutOe());

    always #10 clk_sys = ~clk_sys;

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic miss(input string m);
        $display("mismatch at %0t: %s", $time, m);
        n_errors++;
    endtask
    task automatic cmpBit(input logic g, input logic e, input string m);
        check_count++;
        if (g !== e)
            miss(m);
    endtask
    task automatic cmpByte(input logic [7:0] g, input logic [7:0] e, input string m);
        check_count++;
        if (g !== e)
            miss(m);
    endtask
    task automatic cmpLvl(input lrec_level_type g, input lrec_level_type e, input string m);
        check_count++;
        if (g !== e)
            miss(m);
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask
    task automatic wr(input logic [7:0] dev, input logic [7:0] sub, input logic [7:0] d);
        logic [2:0] a;
        host.startCond();
        host.sendByte(dev, a[2]);
        host.sendByte(sub, a[1]);
        host.sendByte(d, a[0]);
        host.stopCond();
        cmpBit(&a, 1'b1, "write not acknowledged");
    endtask
    task automatic rd(input logic [7:0] sub, output logic [7:0] d);
        logic a;
        host.startCond();
        host.sendByte(`LREC_ADDR_WR, a);
        host.sendByte(sub, a);
        host.startCond();
        host.sendByte(`LREC_ADDR_WR | 8'h01, a);
        host.recvByte(1'b1, d);
        host.stopCond();
    endtask

    always @(posedge clk_sys)
    begin
        cycles <= cycles + 1;
        if (cycles == 60000)
        begin
            miss("timeout");
            tally_and_finish();
        end
    end

    initial
    begin
        logic [7:0] d;
        logic a;
        repeat (20) @(posedge clk_sys);
        sys_rst <= 1'b0;
        settle(6);
        cmpBit(rstOe, 1'b0, "reset out idle");
        cmpLvl(lvl, LREC_1V2, "level default");
        rd(`LREC_OFS_CTLA, d);
        cmpByte(d, 8'h00, "ctl a after reset");
        wr(`LREC_ADDR_WR, `LREC_OFS_CTLA, 8'hff);
        rd(`LREC_OFS_CTLA, d);
        cmpByte(d, 8'h3f, "ctl a readback");
        rd(8'h07, d);
        cmpByte(d, 8'h00, "unmapped read");
        host.startCond();
        host.sendByte(8'h7c, a);
        host.stopCond();
        cmpBit(a, 1'b0, "foreign address");
        foreach (ROWS[i])
        begin
            @(posedge clk_sys);
            en2 <= 1'b0;
            en3 <= 1'b0;
            wr(`LREC_ADDR_WR, `LREC_OFS_CTLA, 8'h00);
            @(posedge clk_sys);
            {stby, low2, low3} <= ROWS[i].io[4:2];
            wr(`LREC_ADDR_WR, `LREC_OFS_CTLA, ROWS[i].ctl);
            @(posedge clk_sys);
            {en2, en3} <= ROWS[i].io[6:5];
            settle(8);
            cmpBit(on2, ROWS[i].io[1], "second rail");
            cmpBit(on3, ROWS[i].io[0], "fixed rail");
            cmpBit(dis2, ~ROWS[i].io[1], "discharge");
        end
        @(posedge clk_sys);
        vin25 <= 1'b0;
        settle(6);
        cmpBit(on2, 1'b0, "lockout");
        cmpBit(aoEn, 1'b1, "always-on kept");
        @(posedge clk_sys);
        vin20 <= 1'b0;
        settle(6);
        cmpBit(aoEn, 1'b0, "always-on off");
        @(posedge clk_sys);
        {vin20, vin25, aoLow, en4} <= 4'hf;
        settle(6);
        cmpBit(rstOe, 1'b1, "reset out low");
        rd(`LREC_OFS_STAT, d);
        cmpByte(d, 8'h1f, "status rails and monitors");
        @(posedge clk_sys);
        aoLow <= 1'b0;
        wr(8'h7a, `LREC_OFS_CTLB, 8'h00);
        settle(6);
        cmpBit(on4T, 1'b0, "term pin ignored");
        cmpBit(on4, 1'b1, "base pin works");
        cmpBit(rstOe, 1'b0, "reset out free");
        for (int c = 0; c < 4; c++)
        begin
            wr(`LREC_ADDR_TERM_WR, `LREC_OFS_CTLB, {3'h0, c[1:0], 3'h4});
            settle(4);
            cmpLvl(lvlT, lv[c], "term level");
            cmpBit(on4T, 1'b1, "term soft enable");
            cmpLvl(lvl, LREC_1V2, "base untouched");
        end
        wr(`LREC_ADDR_WR, `LREC_OFS_CTLA, 8'h24);
        @(posedge clk_sys);
        supLow <= 1'b1;
        settle(6);
        @(posedge clk_sys);
        supLow <= 1'b0;
        rd(`LREC_OFS_CTLA, d);
        cmpByte(d, 8'h00, "serial supply loss");
        wr(`LREC_ADDR_WR, `LREC_OFS_CTLA, 8'h20);
        @(posedge clk_sys);
        sys_rst <= 1'b1;
        settle(2);
        cmpBit(on2, 1'b0, "rail off in reset");
        cmpBit(dis2, 1'b1, "drain on in reset");
        @(posedge clk_sys);
        sys_rst <= 1'b0;
        rd(`LREC_OFS_CTLA, d);
        cmpByte(d, 8'h00, "ctl a after mid-run reset");
        tally_and_finish();
    end
endmodule
